// ### common/psc_map.svh
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// Register byte addresses, one aligned 32-bit word each.
`define PSC_ADDR_ENABLE 8'h00
`define PSC_ADDR_CONV_STEP 8'h04
`define PSC_ADDR_PAUSE_STEP 8'h08
`define PSC_ADDR_PULSE_COUNT 8'h0c
`define PSC_ADDR_CONTROL 8'h10
`define PSC_ADDR_LOW_THR 8'h14
`define PSC_ADDR_HIGH_THR 8'h18
`define PSC_ADDR_PERSIST 8'h1c
`define PSC_ADDR_STATUS 8'h20
`define PSC_ADDR_DATA 8'h24

// Field positions.
`define PSC_EN_POWER_BIT 0
`define PSC_EN_PROX_BIT 1
`define PSC_EN_WAIT_BIT 2
`define PSC_EN_INT_BIT 3
`define PSC_CTL_DRIVE_LSB 0
`define PSC_CTL_CHAN_LSB 2
`define PSC_ST_VALID_BIT 0
`define PSC_ST_INT_BIT 1
`define PSC_ST_STATE_LSB 4

// Reset values.
`define PSC_RST_ENABLE 4'h0
`define PSC_RST_CONV_STEP 8'hff
`define PSC_RST_PAUSE_STEP 8'hff
`define PSC_RST_PULSE_COUNT 8'h01
`define PSC_RST_DRIVE 2'h0
`define PSC_RST_CHAN 2'h1
`define PSC_RST_LOW_THR 16'h0000
`define PSC_RST_HIGH_THR 16'hffff
`define PSC_RST_PERSIST 4'h0

// Timing, in nanoseconds, and the system clock period.
`define PSC_CLK_NS 20
`define PSC_STEP_NS 2720000
`define PSC_PULSE_PERIOD_NS 16000
`define PSC_PULSE_ON_NS 7200

`endif

// ### common/psc_pkg.sv
package psc_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } psc_bus_t;

   typedef struct packed {
      logic [15:0] wideband;
      logic [15:0] infrared;
   } psc_sample_t;

   typedef enum logic [4:0] {
      PSC_SLEEP = 5'h01,
      PSC_IDLE = 5'h02,
      PSC_PULSE = 5'h04,
      PSC_CONV = 5'h08,
      PSC_WAIT = 5'h10
   } psc_state_t;

   typedef enum logic [1:0] {
      PSC_DRIVE_100MA = 2'h0,
      PSC_DRIVE_50MA = 2'h1,
      PSC_DRIVE_25MA = 2'h2,
      PSC_DRIVE_12MA5 = 2'h3
   } psc_drive_t;

endpackage

// ### testbench/psc_host_model.sv
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_host_model (
   input wire logic i_clk_sys,
   input wire logic [31:0] i_rdata,
   output psc_pkg::psc_bus_t o_bus
);
   import psc_pkg::*;
   initial o_bus = '0;
   // A released bus shows the inverse of the last address and data with both strobes low, never a copy.
   task automatic access(input logic [7:0] a, input logic [31:0] d,
                         input logic w, output logic [31:0] q);
      o_bus <= '{addr: a, wdata: d, we: w, re: !w};
      @(posedge i_clk_sys);
      o_bus <= '{addr: ~a, wdata: ~d, we: 1'b0, re: 1'b0};
      @(posedge i_clk_sys);
      q = i_rdata;
   endtask
   task automatic clear_int();
      logic [31:0] q;
      access(`PSC_ADDR_STATUS, 32'h2, 1'b1, q);
   endtask
endmodule

// ### testbench/psc_proximity_ctrl_chk.sv
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_proximity_ctrl_chk (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire psc_pkg::psc_bus_t i_bus,
   input wire psc_pkg::psc_sample_t i_sample,
   input wire logic [31:0] o_rdata,
   input wire logic o_emitter_sink_output,
   input wire logic o_emitter_sink_oe,
   input wire logic [1:0] o_drive_level,
   input wire logic o_int_out,
   input wire logic o_int_oe,
   input wire logic o_low_power,
   input wire logic o_converting
);
   import psc_pkg::*;
   logic [9:0] on_r, on_nxt, off_r, off_nxt;
   logic ien_r, ien_nxt, wr_en, wr_sc;
   assign wr_en = i_ce && i_bus.we && i_bus.addr == `PSC_ADDR_ENABLE;
   assign wr_sc = i_bus.we && (i_bus.addr == `PSC_ADDR_STATUS
                               || i_bus.addr == `PSC_ADDR_ENABLE);
   // The off counter saturates so that the first pulse of a burst is exempt.
   always_comb begin
      on_nxt = o_emitter_sink_oe ? on_r + 10'h1 : 10'h0;
      off_nxt = (o_emitter_sink_oe || off_r == 10'h3ff) ? 10'h3ff : off_r;
      if (!o_emitter_sink_oe && off_r != 10'h3ff)
         off_nxt = off_r + 10'h1;
      if (o_emitter_sink_oe)
         off_nxt = 10'h0;
      ien_nxt = wr_en ? i_bus.wdata[`PSC_EN_INT_BIT] : ien_r;
   end
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         on_r <= 10'h0;
         off_r <= 10'h3ff;
         ien_r <= 1'b0;
      end else begin
         on_r <= on_nxt;
         off_r <= off_nxt;
         ien_r <= ien_nxt;
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   property p_rd_slot;
      o_rdata != 32'h0 |-> $past(i_bus.re) || !$past(i_ce);
   endproperty
   a_rd_slot: assert property (p_rd_slot)
      else $error("read data outside its slot");
   property p_od;
      o_int_out == 1'b0 && o_emitter_sink_output == 1'b0;
   endproperty
   a_od: assert property (p_od)
      else $error("open drain data not low");
   property p_int_hold;
      o_int_oe && !wr_sc && !$past(wr_sc) |=> o_int_oe;
   endproperty
   a_int_hold: assert property (p_int_hold)
      else $error("interrupt dropped without clear");
   property p_int_en; o_int_oe |-> ien_r || $past(ien_r); endproperty
   a_int_en: assert property (p_int_en)
      else $error("interrupt driven while disabled");
   property p_int_src;
      $rose(o_int_oe) |-> $past(o_converting) || $past(o_converting, 2);
   endproperty
   a_int_src: assert property (p_int_src)
      else $error("interrupt without conversion");
   property p_led_on; $fell(o_emitter_sink_oe) |-> on_r == 10'h168; endproperty
   a_led_on: assert property (p_led_on)
      else $error("pulse on time wrong");
   property p_led_off;
      $rose(o_emitter_sink_oe) |-> off_r == 10'h1b8 || off_r == 10'h3ff;
   endproperty
   a_led_off: assert property (p_led_off)
      else $error("pulse period wrong");
   property p_led_act;
      o_emitter_sink_oe |-> !o_low_power && !o_converting;
   endproperty
   a_led_act: assert property (p_led_act)
      else $error("pulse outside pulse phase");
   property p_conv_act; o_converting |-> !o_low_power; endproperty
   a_conv_act: assert property (p_conv_act)
      else $error("low power while converting");
   c_int: cover property ($rose(o_int_oe));
   c_pulse: cover property ($fell(o_emitter_sink_oe));
   c_conv: cover property ($fell(o_converting));
endmodule

bind psc_proximity_ctrl psc_proximity_ctrl_chk u_chk (.*);

// ### testbench/test_proximity_sensor_control.sv
`timescale 1ns/1ps
`include "psc_map.svh"

module test_proximity_sensor_control;
   import psc_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_ce = 1'b1;
   psc_sample_t smp = '0;
   psc_bus_t bus;
   logic [31:0] rdata, q;
   logic led, lp, conv, int_oe, od_led, od_int;
   logic [1:0] drive;
   int failures = 0;
   int samples_checked = 0;
   int rises, on_cyc, lp_cyc, cv_cyc, i;
   logic [31:0] rst_v [11] = '{32'h0, 32'hff, 32'hff, 32'h1, 32'h4, 32'h0,
                               32'hffff, 32'h0, 32'h10, 32'h0, 32'h0};
   logic [31:0] exp_d [4] = '{32'h9000, 32'h9000, 32'h8000, 32'hffff};

   always #10 i_clk_sys = ~i_clk_sys;

   psc_proximity_ctrl #(.STEP_CYCLES(10)) u_dut (
      .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_bus(bus),
      .i_sample(smp), .o_rdata(rdata), .o_emitter_sink_output(od_led),
      .o_emitter_sink_oe(led), .o_drive_level(drive), .o_int_out(od_int),
      .o_int_oe(int_oe), .o_low_power(lp), .o_converting(conv));
   psc_host_model u_host (.i_clk_sys(i_clk_sys), .i_rdata(rdata),
                          .o_bus(bus));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.access(a, d, 1'b1, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      u_host.access(a, 32'h0, 1'b0, q);
      check(q, e);
   endtask
   task automatic int_is(input logic e);
      repeat (2) @(posedge i_clk_sys);
      check(int_oe, e);
   endtask
   // Counts pulses and phase lengths up to the end of the next conversion.
   task automatic conv_done();
      logic seen, led_q;
      seen = 1'b0;
      led_q = led;
      rises = 0;
      on_cyc = 0;
      lp_cyc = 0;
      cv_cyc = 0;
      for (int n = 0; n < 5000; n++) begin
         @(posedge i_clk_sys);
         rises += int'(led && !led_q);
         led_q = led;
         on_cyc += int'(led);
         lp_cyc += int'(lp);
         if (seen && !conv)
            return;
         cv_cyc += int'(conv);
         seen |= conv;
      end
      failures++;
      $display("[FAIL] %0t conversion never ended", $time);
      complete_run();
   endtask

   initial begin
      repeat (4) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      @(posedge i_clk_sys);
      check(lp, 1'b1);
      for (i = 0; i < 11; i++)
         rd_chk(8'(i * 4), rst_v[i]);
      i_ce <= 1'b0;
      wr(`PSC_ADDR_PERSIST, 32'h5);
      i_ce <= 1'b1;
      rd_chk(`PSC_ADDR_PERSIST, 32'h0);
      for (i = 0; i < 4; i++) begin
         wr(`PSC_ADDR_CONTROL, 32'h4 | 32'(i));
         @(posedge i_clk_sys);
         check(32'(drive), 32'(i));
         rd_chk(`PSC_ADDR_CONTROL, 32'h4 | 32'(i));
      end
      $display("register test done");
      smp <= '{wideband: 16'h1234, infrared: 16'h0042};
      wr(`PSC_ADDR_PULSE_COUNT, 32'h3);
      wr(`PSC_ADDR_PAUSE_STEP, 32'h0);
      wr(`PSC_ADDR_ENABLE, 32'h7);
      conv_done();
      check(rises, 3);
      check(on_cyc, 1080);
      rd_chk(`PSC_ADDR_DATA, 32'h1234);
      rd_chk(`PSC_ADDR_STATUS, 32'h101);
      check(lp, 1'b1);
      wr(`PSC_ADDR_ENABLE, 32'h0);
      $display("pulse test done");
      smp <= '{wideband: 16'h9000, infrared: 16'h8000};
      wr(`PSC_ADDR_PULSE_COUNT, 32'h0);
      wr(`PSC_ADDR_CONV_STEP, 32'hfe);
      wr(`PSC_ADDR_PAUSE_STEP, 32'hfe);
      wr(`PSC_ADDR_ENABLE, 32'h7);
      for (i = 0; i < 4; i++) begin
         wr(`PSC_ADDR_CONTROL, 32'(i << 2));
         conv_done();
         conv_done();
         check(lp_cyc, 20);
         check(cv_cyc, 20);
         rd_chk(`PSC_ADDR_DATA, exp_d[i]);
      end
      wr(`PSC_ADDR_ENABLE, 32'h0);
      $display("channel test done");
      wr(`PSC_ADDR_LOW_THR, 32'h100);
      wr(`PSC_ADDR_HIGH_THR, 32'h2000);
      wr(`PSC_ADDR_PERSIST, 32'h2);
      wr(`PSC_ADDR_CONTROL, 32'h4);
      smp <= '{wideband: 16'h3000, infrared: 16'h0};
      wr(`PSC_ADDR_ENABLE, 32'hf);
      conv_done();
      int_is(1'b0);
      conv_done();
      int_is(1'b1);
      rd_chk(`PSC_ADDR_STATUS, 32'h103);
      smp <= '{wideband: 16'h1000, infrared: 16'h0};
      conv_done();
      int_is(1'b1);
      u_host.clear_int();
      int_is(1'b0);
      smp <= '{wideband: 16'h0050, infrared: 16'h0};
      conv_done();
      int_is(1'b0);
      conv_done();
      int_is(1'b1);
      wr(`PSC_ADDR_ENABLE, 32'h7);
      int_is(1'b0);
      conv_done();
      int_is(1'b0);
      wr(`PSC_ADDR_ENABLE, 32'h0);
      @(posedge i_clk_sys);
      check(lp, 1'b1);
      rd_chk(`PSC_ADDR_STATUS, 32'h13);
      check(32'({od_led, od_int}), 32'h0);
      $display("interrupt test done");
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      @(posedge i_clk_sys);
      rd_chk(`PSC_ADDR_STATUS, 32'h10);
      rd_chk(`PSC_ADDR_PERSIST, 32'h0);
      check(int_oe, 1'b0);
      $display("reset test done");
      complete_run();
   end
endmodule

// ### verilog/psc_proximity_ctrl.sv
// Overview of operation
// - Emit programmed 1 to 255 LED pulses.
// - Each LED pulse repeats every 16 us.
// - Sink current selectable among four levels.
// - Interrupt stays asserted until firmware clears it.
// - Interrupt pin driven only when enabled.
// - Interrupt when result above upper or below lower.
// - Interrupt after persistence count of consecutive misses.
// - Copy 16-bit result to data register.
// - Convert both channels; select either or both.
// - Device is a register target for host.
// - Programmable wait between cycles, from 2.72 ms.
// - State machine enters low power between activities.
// - Wait built from 1 to 256 steps.
// - Conversion built from 1 to 256 steps.
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_proximity_ctrl #(
   parameter int STEP_CYCLES = `PSC_STEP_NS / `PSC_CLK_NS
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire psc_pkg::psc_bus_t i_bus,
   input wire psc_pkg::psc_sample_t i_sample,
   output logic [31:0] o_rdata,
   output logic o_emitter_sink_output,
   output logic o_emitter_sink_oe,
   output logic [1:0] o_drive_level,
   output logic o_int_out,
   output logic o_int_oe,
   output logic o_low_power,
   output logic o_converting
);
   import psc_pkg::*;

   localparam int PERIOD_CYCLES = `PSC_PULSE_PERIOD_NS / `PSC_CLK_NS;
   localparam int ON_CYCLES = `PSC_PULSE_ON_NS / `PSC_CLK_NS;

   // Setting 8'hff gives one step and 8'h00 gives 256 steps.
   function automatic logic [8:0] step_total(input logic [7:0] setting);
      step_total = 9'h100 - {1'b0, setting};
   endfunction

   function automatic logic bus_hit(input psc_bus_t b,
                                    input logic [7:0] a);
      bus_hit = (b.addr == a);
   endfunction

   // Configuration and status registers.
   logic [3:0] enable_r, enable_nxt;
   logic [7:0] conv_step_r, conv_step_nxt;
   logic [7:0] pause_step_r, pause_step_nxt;
   logic [7:0] pulse_count_r, pulse_count_nxt;
   logic [1:0] drive_r, drive_nxt;
   logic [1:0] chan_r, chan_nxt;
   logic [15:0] low_thr_r, low_thr_nxt;
   logic [15:0] high_thr_r, high_thr_nxt;
   logic [3:0] persist_r, persist_nxt;
   logic [15:0] data_r, data_nxt;
   logic valid_r, valid_nxt;
   logic int_pend_r, int_pend_nxt;
   logic [3:0] miss_r, miss_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // Sequencer state.
   psc_state_t state_r, state_nxt;
   logic [17:0] cyc_r, cyc_nxt;
   logic [8:0] step_r, step_nxt;
   logic [7:0] pulses_r, pulses_nxt;
   logic led_r, led_nxt;
   logic int_oe_r, int_oe_nxt;
   logic low_power_r, low_power_nxt;
   logic converting_r, converting_nxt;
   logic od_low_r, od_low_nxt;

   logic power_on, prox_en, wait_en, int_en;
   logic conv_done;
   logic [16:0] sum;
   logic [15:0] result;
   logic out_of_range;
   logic [3:0] miss_inc;
   logic clear_int;

   assign power_on = enable_r[`PSC_EN_POWER_BIT];
   assign prox_en = enable_r[`PSC_EN_PROX_BIT];
   assign wait_en = enable_r[`PSC_EN_WAIT_BIT];
   assign int_en = enable_r[`PSC_EN_INT_BIT];

   // Register slave and interrupt bookkeeping.
   always_comb begin
      enable_nxt = enable_r;
      conv_step_nxt = conv_step_r;
      pause_step_nxt = pause_step_r;
      pulse_count_nxt = pulse_count_r;
      drive_nxt = drive_r;
      chan_nxt = chan_r;
      low_thr_nxt = low_thr_r;
      high_thr_nxt = high_thr_r;
      persist_nxt = persist_r;
      data_nxt = data_r;
      valid_nxt = valid_r;
      int_pend_nxt = int_pend_r;
      miss_nxt = miss_r;
      // Read data fall back to zero once their single cycle is over.
      rdata_nxt = 32'h0000_0000;
      clear_int = 1'b0;
      // Both channels are sampled together; the sum saturates.
      sum = {1'b0, i_sample.wideband} + {1'b0, i_sample.infrared};
      case (chan_r)
         2'h2: result = i_sample.infrared;
         2'h3: result = sum[16] ? 16'hffff : sum[15:0];
         default: result = i_sample.wideband;
      endcase
      out_of_range = (result > high_thr_r) || (result < low_thr_r);
      // The miss counter saturates, so a long run never wraps to zero.
      miss_inc = (miss_r == 4'hf) ? miss_r : miss_r + 4'h1;

      if (i_bus.we) begin
         if (bus_hit(i_bus, `PSC_ADDR_ENABLE)) begin
            enable_nxt = i_bus.wdata[3:0];
         end
         if (bus_hit(i_bus, `PSC_ADDR_CONV_STEP)) begin
            conv_step_nxt = i_bus.wdata[7:0];
         end
         if (bus_hit(i_bus, `PSC_ADDR_PAUSE_STEP)) begin
            pause_step_nxt = i_bus.wdata[7:0];
         end
         if (bus_hit(i_bus, `PSC_ADDR_PULSE_COUNT)) begin
            pulse_count_nxt = i_bus.wdata[7:0];
         end
         if (bus_hit(i_bus, `PSC_ADDR_CONTROL)) begin
            drive_nxt = i_bus.wdata[`PSC_CTL_DRIVE_LSB +: 2];
            chan_nxt = i_bus.wdata[`PSC_CTL_CHAN_LSB +: 2];
         end
         if (bus_hit(i_bus, `PSC_ADDR_LOW_THR)) begin
            low_thr_nxt = i_bus.wdata[15:0];
         end
         if (bus_hit(i_bus, `PSC_ADDR_HIGH_THR)) begin
            high_thr_nxt = i_bus.wdata[15:0];
         end
         if (bus_hit(i_bus, `PSC_ADDR_PERSIST)) begin
            persist_nxt = i_bus.wdata[3:0];
         end
         if (bus_hit(i_bus, `PSC_ADDR_STATUS)) begin
            clear_int = i_bus.wdata[`PSC_ST_INT_BIT];
         end
      end

      // Reads have no side effects, so polling never loses an event.
      if (i_bus.re) begin
         case (i_bus.addr)
            `PSC_ADDR_ENABLE: rdata_nxt = {28'h0000000, enable_r};
            `PSC_ADDR_CONV_STEP: rdata_nxt = {24'h000000, conv_step_r};
            `PSC_ADDR_PAUSE_STEP: rdata_nxt = {24'h000000, pause_step_r};
            `PSC_ADDR_PULSE_COUNT: rdata_nxt = {24'h000000, pulse_count_r};
            `PSC_ADDR_CONTROL: rdata_nxt = {28'h0000000, chan_r, drive_r};
            `PSC_ADDR_LOW_THR: rdata_nxt = {16'h0000, low_thr_r};
            `PSC_ADDR_HIGH_THR: rdata_nxt = {16'h0000, high_thr_r};
            `PSC_ADDR_PERSIST: rdata_nxt = {28'h0000000, persist_r};
            `PSC_ADDR_STATUS: begin
               rdata_nxt = 32'h0000_0000;
               rdata_nxt[`PSC_ST_VALID_BIT] = valid_r;
               rdata_nxt[`PSC_ST_INT_BIT] = int_pend_r;
               rdata_nxt[`PSC_ST_STATE_LSB +: 5] = state_r;
            end
            `PSC_ADDR_DATA: rdata_nxt = {16'h0000, data_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      if (clear_int) begin
         int_pend_nxt = 1'b0;
      end

      if (conv_done) begin
         data_nxt = result;
         valid_nxt = 1'b1;
         if (out_of_range) begin
            miss_nxt = miss_inc;
            // A persistence of zero fires on every miss.
            if (int_en && (miss_inc >= persist_r)) begin
               int_pend_nxt = 1'b1;
            end
         end else begin
            miss_nxt = 4'h0;
         end
      end
      // Held as a level until firmware clears it; a new event wins.
      int_oe_nxt = int_pend_nxt && int_en;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         enable_r <= `PSC_RST_ENABLE;
         conv_step_r <= `PSC_RST_CONV_STEP;
         pause_step_r <= `PSC_RST_PAUSE_STEP;
         pulse_count_r <= `PSC_RST_PULSE_COUNT;
         drive_r <= `PSC_RST_DRIVE;
         chan_r <= `PSC_RST_CHAN;
         low_thr_r <= `PSC_RST_LOW_THR;
         high_thr_r <= `PSC_RST_HIGH_THR;
         persist_r <= `PSC_RST_PERSIST;
         data_r <= 16'h0000;
         valid_r <= 1'b0;
         int_pend_r <= 1'b0;
         miss_r <= 4'h0;
         rdata_r <= 32'h0000_0000;
         int_oe_r <= 1'b0;
      end else if (i_ce) begin
         // A low clock enable freezes settings and read data alike.
         enable_r <= enable_nxt;
         conv_step_r <= conv_step_nxt;
         pause_step_r <= pause_step_nxt;
         pulse_count_r <= pulse_count_nxt;
         drive_r <= drive_nxt;
         chan_r <= chan_nxt;
         low_thr_r <= low_thr_nxt;
         high_thr_r <= high_thr_nxt;
         persist_r <= persist_nxt;
         data_r <= data_nxt;
         valid_r <= valid_nxt;
         int_pend_r <= int_pend_nxt;
         miss_r <= miss_nxt;
         rdata_r <= rdata_nxt;
         int_oe_r <= int_oe_nxt;
      end
   end

   // Cycle sequencer: pulses, conversion, optional wait.
   always_comb begin
      state_nxt = state_r;
      cyc_nxt = cyc_r;
      step_nxt = step_r;
      pulses_nxt = pulses_r;
      conv_done = 1'b0;
      case (state_r)
         PSC_SLEEP: begin
            if (power_on) begin
               state_nxt = PSC_IDLE;
            end
         end
         PSC_IDLE: begin
            cyc_nxt = 18'h00000;
            step_nxt = 9'h000;
            pulses_nxt = 8'h00;
            if (prox_en) begin
               // A pulse count of zero skips straight to conversion.
               state_nxt = (pulse_count_r != 8'h00) ? PSC_PULSE
                                                    : PSC_CONV;
            end else if (wait_en) begin
               state_nxt = PSC_WAIT;
            end
         end
         PSC_PULSE: begin
            cyc_nxt = cyc_r + 18'h00001;
            if (cyc_r == 18'(PERIOD_CYCLES - 1)) begin
               cyc_nxt = 18'h00000;
               pulses_nxt = pulses_r + 8'h01;
               // A count lowered in mid-burst lets this counter wrap.
               if (pulses_r == pulse_count_r - 8'h01) begin
                  pulses_nxt = 8'h00;
                  state_nxt = PSC_CONV;
               end
            end
         end
         PSC_CONV: begin
            cyc_nxt = cyc_r + 18'h00001;
            if (cyc_r == 18'(STEP_CYCLES - 1)) begin
               cyc_nxt = 18'h00000;
               step_nxt = step_r + 9'h001;
               if (step_r == step_total(conv_step_r) - 9'h001) begin
                  step_nxt = 9'h000;
                  // The photodiode words are taken at this final step only.
                  conv_done = 1'b1;
                  state_nxt = wait_en ? PSC_WAIT : PSC_IDLE;
               end
            end
         end
         PSC_WAIT: begin
            cyc_nxt = cyc_r + 18'h00001;
            if (cyc_r == 18'(STEP_CYCLES - 1)) begin
               cyc_nxt = 18'h00000;
               step_nxt = step_r + 9'h001;
               if (step_r == step_total(pause_step_r) - 9'h001) begin
                  step_nxt = 9'h000;
                  state_nxt = PSC_IDLE;
               end
            end
         end
         default: begin
            state_nxt = PSC_SLEEP;
         end
      endcase
      // Dropping power aborts any cycle; a conversion in flight is lost unless power drops in its final cycle, whose result is still stored.
      if (!power_on) begin
         state_nxt = PSC_SLEEP;
         cyc_nxt = 18'h00000;
         step_nxt = 9'h000;
         pulses_nxt = 8'h00;
      end
      led_nxt = (state_nxt == PSC_PULSE) &&
                (cyc_nxt < 18'(ON_CYCLES));
      low_power_nxt = (state_nxt == PSC_SLEEP) ||
                      (state_nxt == PSC_WAIT);
      converting_nxt = (state_nxt == PSC_CONV);
      // Open-drain data lines only ever pull low; the enables carry the pins.
      od_low_nxt = 1'b0;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r <= PSC_SLEEP;
         cyc_r <= 18'h00000;
         step_r <= 9'h000;
         pulses_r <= 8'h00;
         led_r <= 1'b0;
         low_power_r <= 1'b1;
         converting_r <= 1'b0;
         od_low_r <= 1'b0;
      end else if (i_ce) begin
         state_r <= state_nxt;
         cyc_r <= cyc_nxt;
         step_r <= step_nxt;
         pulses_r <= pulses_nxt;
         led_r <= led_nxt;
         low_power_r <= low_power_nxt;
         converting_r <= converting_nxt;
         od_low_r <= od_low_nxt;
      end
   end

   // Every pin comes straight from a flop, so no glitch reaches the board.
   assign o_rdata = rdata_r;
   assign o_emitter_sink_output = od_low_r;
   assign o_emitter_sink_oe = led_r;
   assign o_drive_level = drive_r;
   assign o_int_out = od_low_r;
   assign o_int_oe = int_oe_r;
   assign o_low_power = low_power_r;
   assign o_converting = converting_r;

endmodule
